// [core/temp_alarm_alert_logic.sv]
// Alarm, alert response, standby and fault logic of a two-channel temperature monitor
`timescale 1ns/1ns
// How it works
// - First write byte loads pointer, second writes
// - Bare read returns pointer-selected register
// - Writes only at write locations, reads read locations
// - Alert on out-of-limit or open diode
// - Alert pin only pulls low
// - Answer alert address with own address, a one below it
// - Lose arbitration when sent one reads zero
// - Release alert after answer if cause cleared
// - Config bit 6 standby aborts running conversion
// - Serial bus keeps working in standby
// - Single conversion location triggers one conversion in standby
// - Limits writable in standby, alert still raised
// - Alert maskable, critical output never masked
// - Alert when temperature at or below low
// - Alert when temperature above high limit
// - Critical output low above own critical limit
// - One hysteresis value, default ten, both channels
// - Open comparator sampled at conversion start
// - Shorted diode reads minus 128, flags low
// - Fixed device address 4C
module temp_alarm_alert_logic #(
  parameter logic [7:0] IDENT_CODE = 8'h5A  // Arbitrary identification value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial bus pins
  input wire logic serial_clock_line,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  // Open-drain alarm pins
  output logic alert_n_out,
  output logic alert_n_oe,
  output logic critical_temp_n_out,
  output logic critical_temp_n_oe,
  // Converter
  output logic conv_start,
  output logic conv_abort,
  input wire logic conv_done,
  input wire logic [7:0] local_result,
  input wire logic [7:0] remote_result,
  input wire logic diode_open
);

  typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, WRITE, WRITE_ACK, READ, READ_ACK} smb_state_type;

  logic [1:0] rst_pipe;
  logic rst_n;
  logic scl, sda, scl_rise, scl_fall, bus_start, bus_stop;
  smb_state_type state;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [3:0] bit_cnt;
  logic first_byte;
  logic is_read;
  logic is_ara;
  logic acked;
  logic sda_low;
  logic reg_wr;
  logic [7:0] wr_data;
  logic ara_done;
  logic [7:0] pointer;
  logic [7:0] config_reg, local_high, local_low, remote_high, remote_low;
  logic [7:0] local_crit, remote_crit, crit_hyst, local_temp, remote_temp;
  logic remote_open;
  logic busy, single_pend;
  logic open_meta, open_sync;
  logic alert_latched;
  logic critical_temp_n_local, critical_temp_n_remote;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  smbus_line_sampler u_sampler (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_pin(serial_clock_line),
    .sda_pin(serial_data_line_in),
    .scl(scl),
    .sda(sda),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .bus_start(bus_start),
    .bus_stop(bus_stop)
  );

  // ----------------------------------------------------------------
  // Signed compares
  // ----------------------------------------------------------------
  function automatic logic at_or_below(input logic [7:0] t, input logic [7:0] lim);
    at_or_below = $signed(t) <= $signed(lim);
  endfunction

  function automatic logic above(input logic [7:0] t, input logic [7:0] lim);
    above = $signed(t) > $signed(lim);
  endfunction

  // Ten bits so a limit minus a full hysteresis cannot wrap
  function automatic logic below_release(input logic [7:0] t, input logic [7:0] lim, input logic [7:0] h);
    below_release = $signed({{2{t[7]}}, t}) < ($signed({{2{lim[7]}}, lim}) - $signed({2'b00, h}));
  endfunction

  // ----------------------------------------------------------------
  // Limit evaluation
  // ----------------------------------------------------------------
  // Live compare, stored values
  wire loc_high_hit = above(local_temp, local_high);
  wire rem_high_hit = above(remote_temp, remote_high);
  // Minus 128 always at or below
  wire loc_low_hit = at_or_below(local_temp, local_low);
  wire rem_low_hit = at_or_below(remote_temp, remote_low);
  wire alert_cond = loc_high_hit || rem_high_hit || loc_low_hit || rem_low_hit || remote_open;
  wire alert_masked = config_reg[temp_alarm_pkg::CFG_ALERT_MASK];
  wire standby = config_reg[temp_alarm_pkg::CFG_STANDBY];
  wire loc_over_crit = above(local_temp, local_crit);
  wire rem_over_crit = above(remote_temp, remote_crit);

  // ----------------------------------------------------------------
  // Serial slave decode
  // ----------------------------------------------------------------
  wire byte_done = (bit_cnt == temp_alarm_pkg::BITS_PER_BYTE);
  wire addr_dev = (shift[7:1] == temp_alarm_pkg::DEVICE_ADDR);
  wire addr_ara = (shift[7:1] == temp_alarm_pkg::ALERT_RESPONSE_ADDR) && shift[0] && alert_latched;
  wire arb_lost = is_ara && tx[7] && !sda;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      shift <= 8'h00;
      tx <= 8'h00;
      bit_cnt <= 4'h0;
      first_byte <= 1'b0;
      is_read <= 1'b0;
      is_ara <= 1'b0;
      acked <= 1'b0;
      sda_low <= 1'b0;
      reg_wr <= 1'b0;
      wr_data <= 8'h00;
      ara_done <= 1'b0;
      pointer <= 8'h00;
    end else begin
      reg_wr <= 1'b0;
      ara_done <= 1'b0;
      if (bus_start) begin
        state <= ADDR;
        bit_cnt <= 4'h0;
        sda_low <= 1'b0;
      end else if (bus_stop) begin
        state <= IDLE;
        sda_low <= 1'b0;
      end else begin
        unique case (state)
          IDLE: begin
            sda_low <= 1'b0;
          end
          ADDR: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && byte_done) begin
              // Acknowledge alert address only while asserting
              if (addr_dev || addr_ara) begin
                state <= ADDR_ACK;
                sda_low <= 1'b1;
                is_read <= shift[0];
                is_ara <= !addr_dev;
              end else begin
                state <= IDLE;
              end
            end
          end
          ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              first_byte <= 1'b1;
              if (is_read) begin
                // Own address with a one below
                // Data from pointer as it stands
                tx <= is_ara ? {temp_alarm_pkg::DEVICE_ADDR, 1'b1} : rd_byte;
                sda_low <= is_ara ? !temp_alarm_pkg::DEVICE_ADDR[6] : !rd_byte[7];
                state <= READ;
              end else begin
                sda_low <= 1'b0;
                state <= WRITE;
              end
            end
          end
          WRITE: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && byte_done) begin
              sda_low <= 1'b1;
              state <= WRITE_ACK;
              first_byte <= 1'b0;
              if (first_byte) begin
                pointer <= shift;
              end else begin
                reg_wr <= 1'b1;
                wr_data <= shift;
              end
            end
          end
          WRITE_ACK: begin
            if (scl_fall) begin
              sda_low <= 1'b0;
              bit_cnt <= 4'h0;
              state <= WRITE;
            end
          end
          READ: begin
            if (scl_rise) begin
              if (arb_lost) begin
                state <= IDLE;
                sda_low <= 1'b0;
              end else begin
                tx <= {tx[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end else if (scl_fall) begin
              if (byte_done) begin
                sda_low <= 1'b0;
                state <= READ_ACK;
                ara_done <= is_ara;
              end else begin
                sda_low <= !tx[7];
              end
            end
          end
          READ_ACK: begin
            if (scl_rise) begin
              acked <= !sda;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (acked && !is_ara) begin
                tx <= rd_byte;
                sda_low <= !rd_byte[7];
                state <= READ;
              end else begin
                state <= IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // Data pin only ever pulled low
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe = sda_low;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Write locations decoded apart
  wire wr_cfg = reg_wr && (pointer == temp_alarm_pkg::WR_CONFIG);
  wire wr_lhi = reg_wr && (pointer == temp_alarm_pkg::WR_LOCAL_HIGH);
  wire wr_llo = reg_wr && (pointer == temp_alarm_pkg::WR_LOCAL_LOW);
  wire wr_rhi = reg_wr && (pointer == temp_alarm_pkg::WR_REMOTE_HIGH);
  wire wr_rlo = reg_wr && (pointer == temp_alarm_pkg::WR_REMOTE_LOW);
  wire wr_rcr = reg_wr && (pointer == temp_alarm_pkg::RW_REMOTE_CRIT);
  wire wr_lcr = reg_wr && (pointer == temp_alarm_pkg::RW_LOCAL_CRIT);
  wire wr_hys = reg_wr && (pointer == temp_alarm_pkg::RW_CRIT_HYST);
  wire wr_single = reg_wr && (pointer == temp_alarm_pkg::WR_SINGLE_CONV);

  // Limit writes accepted in any mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= temp_alarm_pkg::CONFIG_RESET;
      local_high <= temp_alarm_pkg::HIGH_LIMIT_RESET;
      local_low <= temp_alarm_pkg::LOW_LIMIT_RESET;
      remote_high <= temp_alarm_pkg::HIGH_LIMIT_RESET;
      remote_low <= temp_alarm_pkg::LOW_LIMIT_RESET;
      local_crit <= temp_alarm_pkg::CRIT_LIMIT_RESET;
      remote_crit <= temp_alarm_pkg::CRIT_LIMIT_RESET;
      crit_hyst <= temp_alarm_pkg::CRIT_HYST_RESET;
    end else begin
      if (wr_cfg) config_reg <= wr_data;
      if (wr_lhi) local_high <= wr_data;
      if (wr_llo) local_low <= wr_data;
      if (wr_rhi) remote_high <= wr_data;
      if (wr_rlo) remote_low <= wr_data;
      if (wr_lcr) local_crit <= wr_data;
      if (wr_rcr) remote_crit <= wr_data;
      if (wr_hys) crit_hyst <= wr_data;
    end
  end

  wire [7:0] status_byte = {busy, loc_high_hit, loc_low_hit, rem_high_hit, rem_low_hit, remote_open, 2'b00};

  always_comb begin
    unique case (pointer)
      temp_alarm_pkg::RD_LOCAL_TEMP: rd_byte = local_temp;
      temp_alarm_pkg::RD_REMOTE_TEMP: rd_byte = remote_temp;
      temp_alarm_pkg::RD_STATUS: rd_byte = status_byte;
      temp_alarm_pkg::RD_CONFIG: rd_byte = config_reg;
      temp_alarm_pkg::RD_LOCAL_HIGH: rd_byte = local_high;
      temp_alarm_pkg::RD_LOCAL_LOW: rd_byte = local_low;
      temp_alarm_pkg::RD_REMOTE_HIGH: rd_byte = remote_high;
      temp_alarm_pkg::RD_REMOTE_LOW: rd_byte = remote_low;
      temp_alarm_pkg::RW_REMOTE_CRIT: rd_byte = remote_crit;
      temp_alarm_pkg::RW_LOCAL_CRIT: rd_byte = local_crit;
      temp_alarm_pkg::RW_CRIT_HYST: rd_byte = crit_hyst;
      temp_alarm_pkg::RD_IDENT: rd_byte = IDENT_CODE;
      default: rd_byte = temp_alarm_pkg::UNMAPPED_READ;
    endcase
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  wire start_now = !busy && (!standby || single_pend);
  wire abort_now = busy && standby && !single_pend;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_meta <= 1'b0;
      open_sync <= 1'b0;
      busy <= 1'b0;
      single_pend <= 1'b0;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      remote_open <= 1'b0;
      local_temp <= temp_alarm_pkg::TEMP_RESET;
      remote_temp <= temp_alarm_pkg::TEMP_RESET;
    end else begin
      open_meta <= diode_open;
      open_sync <= open_meta;
      conv_start <= start_now;
      conv_abort <= abort_now;
      if (start_now) begin
        busy <= 1'b1;
        remote_open <= open_sync;
      end else if (abort_now) begin
        busy <= 1'b0;
      end else if (busy && conv_done) begin
        busy <= 1'b0;
        local_temp <= local_result;
        remote_temp <= remote_result;
      end
      // One conversion, then back to standby
      if (wr_single && standby) begin
        single_pend <= 1'b1;
      end else if (busy && conv_done) begin
        single_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_latched <= 1'b0;
      critical_temp_n_local <= 1'b0;
      critical_temp_n_remote <= 1'b0;
    end else begin
      // Cleared by answer only once cause gone
      alert_latched <= (alert_cond && !alert_masked) || (alert_latched && !(ara_done && !alert_cond));
      critical_temp_n_local <= loc_over_crit || (critical_temp_n_local && !below_release(local_temp, local_crit, crit_hyst));
      critical_temp_n_remote <= rem_over_crit || (critical_temp_n_remote && !below_release(remote_temp, remote_crit, crit_hyst));
    end
  end

  assign alert_n_out = 1'b0;
  assign alert_n_oe = alert_latched;
  assign critical_temp_n_out = 1'b0;
  assign critical_temp_n_oe = critical_temp_n_local || critical_temp_n_remote;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  alert_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (alert_cond && !alert_masked) |=> alert_n_oe) else $error("alert not raised on cause");
  alert_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (alert_n_oe && alert_cond) |=> alert_n_oe) else $error("alert released while cause stands");
  alert_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (alert_n_oe && ara_done && !alert_cond && !(alert_cond && !alert_masked)) |=> !alert_n_oe)
    else $error("alert kept after answer");
  pin_polarity_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !alert_n_out && !critical_temp_n_out && !serial_data_line_out) else $error("open drain drove high");
  crit_unmasked_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (loc_over_crit || rem_over_crit) |=> critical_temp_n_oe) else $error("critical not driven");
  crit_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(critical_temp_n_oe) |-> $past(loc_over_crit || rem_over_crit)) else $error("critical rose without cause");
  low_inclusive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (local_temp == local_low) |-> loc_low_hit) else $error("equal low limit not flagged");
  standby_abort_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    abort_now |=> !busy ##0 conv_abort) else $error("standby did not abort");
  no_store_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (conv_done && !busy) |=> $stable(local_temp) && $stable(remote_temp)) else $error("stale result stored");
  pointer_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == WRITE && scl_fall && byte_done && first_byte && !bus_start && !bus_stop) |=> pointer == $past(shift))
    else $error("pointer not loaded");
  ara_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ADDR_ACK && is_ara) |-> alert_latched) else $error("alert address acked without alert");

endmodule

// [core/temp_alarm_pkg.sv]
// Register map, reset values and bus constants of the temperature alarm block
package temp_alarm_pkg;

  // ----------------------------------------------------------------
  // Serial bus addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] DEVICE_ADDR = 7'h4C;
  localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;

  // ----------------------------------------------------------------
  // Read locations
  // ----------------------------------------------------------------
  localparam logic [7:0] RD_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] RD_REMOTE_TEMP = 8'h01;
  localparam logic [7:0] RD_STATUS = 8'h02;
  localparam logic [7:0] RD_CONFIG = 8'h03;
  localparam logic [7:0] RD_LOCAL_HIGH = 8'h05;
  localparam logic [7:0] RD_LOCAL_LOW = 8'h06;
  localparam logic [7:0] RD_REMOTE_HIGH = 8'h07;
  localparam logic [7:0] RD_REMOTE_LOW = 8'h08;
  localparam logic [7:0] RD_IDENT = 8'hFE;

  // ----------------------------------------------------------------
  // Write locations
  // ----------------------------------------------------------------
  localparam logic [7:0] WR_CONFIG = 8'h09;
  localparam logic [7:0] WR_LOCAL_HIGH = 8'h0B;
  localparam logic [7:0] WR_LOCAL_LOW = 8'h0C;
  localparam logic [7:0] WR_REMOTE_HIGH = 8'h0D;
  localparam logic [7:0] WR_REMOTE_LOW = 8'h0E;
  localparam logic [7:0] WR_SINGLE_CONV = 8'h0F;

  // ----------------------------------------------------------------
  // Shared read and write locations
  // ----------------------------------------------------------------
  localparam logic [7:0] RW_REMOTE_CRIT = 8'h19;
  localparam logic [7:0] RW_LOCAL_CRIT = 8'h20;
  localparam logic [7:0] RW_CRIT_HYST = 8'h21;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] HIGH_LIMIT_RESET = 8'h55;
  localparam logic [7:0] LOW_LIMIT_RESET = 8'h00;
  localparam logic [7:0] CRIT_LIMIT_RESET = 8'h55;
  localparam logic [7:0] CRIT_HYST_RESET = 8'h0A;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_ALERT_MASK = 7;
  localparam int CFG_STANDBY = 6;
  localparam int ST_BUSY = 7;
  localparam int ST_LOCAL_HIGH = 6;
  localparam int ST_LOCAL_LOW = 5;
  localparam int ST_REMOTE_HIGH = 4;
  localparam int ST_REMOTE_LOW = 3;
  localparam int ST_REMOTE_OPEN = 2;

  // ----------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage

// [core/smbus_line_sampler.sv]
// Synchroniser and start, stop and edge finder for the serial bus pins
`timescale 1ns/1ns
module smbus_line_sampler (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Raw pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  // Sampled view
  output logic scl,
  output logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic bus_start,
  output logic bus_stop
);

  logic scl_meta;
  logic sda_meta;
  logic scl_sync;
  logic sda_sync;
  logic scl_prev;
  logic sda_prev;

  // ----------------------------------------------------------------
  // Two stages, then one more for edges
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta <= 1'b1;
      sda_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_pin;
      sda_meta <= sda_pin;
      scl_sync <= scl_meta;
      sda_sync <= sda_meta;
      scl_prev <= scl_sync;
      sda_prev <= sda_sync;
    end
  end

  assign scl = scl_sync;
  assign sda = sda_sync;
  assign scl_rise = scl_sync && !scl_prev;
  assign scl_fall = !scl_sync && scl_prev;
  // Data moving while the clock is high frames a transfer
  assign bus_start = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign bus_stop = scl_sync && scl_prev && !sda_prev && sda_sync;

endmodule

// [verification/smbus_host_model.sv]
// Serial bus host stand-in: drives the clock and pulls the data line
`timescale 1ns/1ns
module smbus_host_model (
  // Bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Data moves mid low phase, never while the clock is high
  task automatic put_bit(input logic b);
    sda_pull = !b;
    #16 scl = 1'b1;
    #32 scl = 1'b0;
    #16;
  endtask
  task automatic get_bit(output logic b);
    sda_pull = 1'b0;
    #16 scl = 1'b1;
    #16 b = sda;
    #16 scl = 1'b0;
    #16;
  endtask
  task automatic start();
    sda_pull = 1'b1;
    #32 scl = 1'b0;
    #32;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    #16 scl = 1'b1;
    #32 sda_pull = 1'b0;
    #32;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack);
    ack = !ack;
  endtask
  task automatic recv(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
  endtask
endmodule

// [verification/tb_top.sv]
// Testbench of the temperature alarm block with a converter stand-in
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic scl, sda_pull, sda_oe, sda_out, alert_oe, alert_out, crit_oe, crit_out, conv_start, conv_abort;
  logic conv_done = 1'b0;
  logic diode_open = 1'b0;
  logic [7:0] lt = 8'h19;
  logic [7:0] rt = 8'h19;
  logic [3:0] cnt = 4'h0;
  int errors = 0;
  int cmp_count = 0;
  int starts = 0;
  wire sda = !(sda_pull || (sda_oe && !sda_out));
  always #4 sys_clk = !sys_clk;
  smbus_host_model u_host (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  temp_alarm_alert_logic u_temp_alarm_alert_logic (.sys_clk(sys_clk), .resetn(resetn), .serial_clock_line(scl),
    .serial_data_line_in(sda), .serial_data_line_out(sda_out), .serial_data_line_oe(sda_oe),
    .alert_n_out(alert_out), .alert_n_oe(alert_oe), .critical_temp_n_out(crit_out), .critical_temp_n_oe(crit_oe),
    .conv_start(conv_start), .conv_abort(conv_abort), .conv_done(conv_done), .local_result(lt),
    .remote_result(rt), .diode_open(diode_open));
  // Five-cycle conversion; an abort drops it
  always @(negedge sys_clk) begin
    conv_done <= (cnt == 4'h1);
    if (conv_start === 1'b1) starts <= starts + 1;
    if (conv_start === 1'b1) cnt <= 4'h5;
    else if (conv_abort === 1'b1) cnt <= 4'h0;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  task automatic finish_test();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] q, output logic ack);
    q = 8'h00;
    u_host.start();
    u_host.send({a, 1'b1}, ack);
    if (ack) u_host.recv(q);
    u_host.stop();
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic two);
    logic ack;
    u_host.start();
    u_host.send({7'h4C, 1'b0}, ack);
    `CHK(ack, 1'b1)
    u_host.send(p, ack);
    if (two) u_host.send(d, ack);
    u_host.stop();
  endtask
  task automatic chk_reg(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] q;
    logic ack;
    wr(p, 8'h00, 1'b0);
    rd(7'h4C, q, ack);
    `CHK(q, e)
  endtask
  // Timeout ends the run: a hung pin never passes
  task automatic wait_pin(input logic crit, input logic e);
    for (int i = 0; i < 300 && (crit ? crit_oe : alert_oe) !== e; i++) @(negedge sys_clk);
    `CHK(crit ? crit_oe : alert_oe, e)
    if ((crit ? crit_oe : alert_oe) !== e) finish_test();
  endtask
  task automatic t_regs();
    logic [7:0] q;
    logic ack;
    chk_reg(8'h21, 8'h0A);
    rd(7'h4C, q, ack);
    `CHK(q, 8'h0A)
    wr(8'h0C, 8'h05, 1'b1);
    chk_reg(8'h06, 8'h05);
    chk_reg(8'h0C, 8'h00);
  endtask
  task automatic t_alert();
    logic [7:0] q;
    logic ack;
    rd(7'h0C, q, ack);
    wait_pin(1'b0, 1'b0);
    rd(7'h0C, q, ack);
    `CHK(ack, 1'b0)
    rt = 8'h56;
    wait_pin(1'b0, 1'b1);
    `CHK(alert_out, 1'b0)
    rd(7'h0C, q, ack);
    `CHK(q, 8'h99)
    `CHK(alert_oe, 1'b1)
    rt = 8'h80;
    rd(7'h0C, q, ack);
    `CHK(alert_oe, 1'b1)
    rt = 8'h19;
    for (int i = 0; i < 4 && alert_oe === 1'b1; i++) rd(7'h0C, q, ack);
    wait_pin(1'b0, 1'b0);
  endtask
  task automatic t_crit();
    wr(8'h09, 8'h80, 1'b1);
    lt = 8'h56;
    wait_pin(1'b1, 1'b1);
    `CHK(crit_out, 1'b0)
    `CHK(alert_oe, 1'b0)
    lt = 8'h4B;
    wr(8'h09, 8'h00, 1'b1);
    `CHK(crit_oe, 1'b1)
    lt = 8'h4A;
    wait_pin(1'b1, 1'b0);
  endtask
  task automatic t_standby();
    int s;
    wr(8'h09, 8'h40, 1'b1);
    s = starts;
    lt = 8'h60;
    wr(8'h0C, 8'h4A, 1'b1);
    wait_pin(1'b0, 1'b1);
    `CHK(starts, s)
    wr(8'h0F, 8'hA5, 1'b1);
    chk_reg(8'h00, 8'h60);
    `CHK(starts, s + 1)
  endtask
  // Open diode alone keeps alert; flag holds its start sample
  task automatic t_open();
    logic [7:0] q;
    logic ack;
    lt = 8'h4B;
    diode_open = 1'b1;
    wr(8'h0F, 8'h00, 1'b1);
    rd(7'h0C, q, ack);
    `CHK(q, 8'h99)
    `CHK(alert_oe, 1'b1)
    chk_reg(8'h02, 8'h04);
    diode_open = 1'b0;
    chk_reg(8'h02, 8'h04);
  endtask
  initial begin
    #400000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (10) @(negedge sys_clk);
    t_regs();
    t_alert();
    t_crit();
    t_standby();
    t_open();
    finish_test();
  end
endmodule
